// >>> logic/osr_regs.sv
// Behaviour
// - per-channel source mask; lowest set bit of own parity supplies data
// - first line is 9 bits, msb in bit 0 of high register
// - first line commits from both halves only on low write
// - last line is 9 bits, msb in bit 0 of high register
// - last line commits only on low write
// - commit applies at once if immediate flag, else at field start
// - pixel group is 16 bits, leftmost pixel in top nibble
// - column index 8 bits, valid 0..177
// - column auto step after multi-write, saturating at 177
// - row index 9 bits, msb in bit 0 of high register
// - row auto step after multi-write, saturating at 511
// - sync loss register, one flag per channel, zero when all valid
// - flag sets when sync absent longer than one line period
// - trigger bit n writes pixel group at column/row to channel n
// - trigger register clears itself when all writes complete
// - control register: row step bit 4, column step bit 3
// - overlay key low selects fill, high selects camera
// - lines first..last fetched from source channel, others own
// - sync loss flag clears when valid sync seen again
// - suppress bit forces overlay key inactive
//
// Local design decisions: the register offsets and the APB slave port.
`include "osr_map.svh"
`default_nettype none
module osr_regs
  import osr_pkg::*;
#(
  parameter int NCH = 8,
  parameter logic [9:0] LINE_CYC = 10'(`OSR_LINE_CYC)
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // video timing
  input wire logic [7:0] sync_in,
  input wire logic field_start,
  input wire logic [7:0] gfx_on,
  output logic [7:0] overlay_key_n,
  // display fetch
  input wire logic fetch_req,
  input wire logic [2:0] fetch_chan,
  input wire logic [8:0] fetch_line,
  output logic fetch_valid,
  output logic [2:0] fetch_mem_chan,
  // frame memory write
  output logic mem_wr_req,
  output osr_memwr_s mem_wr,
  input wire logic mem_wr_ack
);
  // ==========================================================
  // apb decode
  logic [7:0] idx;
  logic [3:0] blk;
  logic [3:0] rg;
  logic hit;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic wr;
  osr_mw_e mw_reg, mw_next;

  assign idx = paddr[9:2];
  assign blk = idx[7:4];
  assign rg = idx[3:0];
  always_comb
  begin
    hit = 1'b0;
    if (paddr[31:10] == 22'h000000 && paddr[1:0] == 2'h0)
    begin
      if (blk == `OSR_BLK_MULTI)
        hit = (rg <= `OSR_MC_CTRL);
      else if (blk < `OSR_BLK_MULTI)
        hit = (rg == `OSR_CH_STATUS) ||
              (rg >= `OSR_CH_SRC && rg <= `OSR_CH_LAST_L);
    end
  end
  assign wr = psel & penable & pready_reg & pwrite & ~pslverr_reg;

  // ==========================================================
  // register storage
  logic [7:0] src_reg [NCH];
  logic [7:0] src_next [NCH];
  logic fh_reg [NCH];
  logic fh_next [NCH];
  logic [7:0] fl_reg [NCH];
  logic [7:0] fl_next [NCH];
  logic lh_reg [NCH];
  logic lh_next [NCH];
  logic [7:0] ll_reg [NCH];
  logic [7:0] ll_next [NCH];
  osr_share_s pend_reg [NCH];
  osr_share_s pend_next [NCH];
  osr_share_s act_reg [NCH];
  osr_share_s act_next [NCH];
  logic [7:0] pendf_reg, pendf_next;
  logic [7:0] blank_reg, blank_next;
  logic [7:0] imm_reg, imm_next;
  logic [7:0] lost_reg, lost_next;
  logic [15:0] pix_reg, pix_next;
  logic [7:0] col_reg, col_next;
  logic [8:0] row_reg, row_next;
  logic [7:0] trig_reg, trig_next;
  logic col_step_reg, col_step_next;
  logic row_step_reg, row_step_next;

  always_comb
  begin
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~hit;
    prdata_next = 32'h00000000;
    if (psel && !penable && hit)
    begin
      if (blk == `OSR_BLK_MULTI)
        case (rg)
          `OSR_MC_PIX_H: prdata_next[7:0] = pix_reg[15:8];
          `OSR_MC_PIX_L: prdata_next[7:0] = pix_reg[7:0];
          `OSR_MC_COL: prdata_next[7:0] = col_reg;
          `OSR_MC_ROW_H: prdata_next[0] = row_reg[8];
          `OSR_MC_ROW_L: prdata_next[7:0] = row_reg[7:0];
          `OSR_MC_LOSS: prdata_next[7:0] = lost_reg;
          `OSR_MC_TRIG: prdata_next[7:0] = trig_reg;
          `OSR_MC_CTRL:
          begin
            prdata_next[`OSR_CTL_COL] = col_step_reg;
            prdata_next[`OSR_CTL_ROW] = row_step_reg;
          end
          default: prdata_next = 32'h00000000;
        endcase
      else
        case (rg)
          `OSR_CH_STATUS:
          begin
            prdata_next[`OSR_ST_LOST] = lost_reg[blk[2:0]];
            prdata_next[`OSR_ST_BLANK] = blank_reg[blk[2:0]];
            prdata_next[`OSR_ST_IMM] = imm_reg[blk[2:0]];
          end
          `OSR_CH_SRC: prdata_next[7:0] = src_reg[blk[2:0]];
          `OSR_CH_FIRST_H: prdata_next[0] = fh_reg[blk[2:0]];
          `OSR_CH_FIRST_L: prdata_next[7:0] = fl_reg[blk[2:0]];
          `OSR_CH_LAST_H: prdata_next[0] = lh_reg[blk[2:0]];
          `OSR_CH_LAST_L: prdata_next[7:0] = ll_reg[blk[2:0]];
          default: prdata_next = 32'h00000000;
        endcase
    end
  end

  // ==========================================================
  // per-channel share registers and commit
  always_comb
  begin
    pendf_next = pendf_reg;
    blank_next = blank_reg;
    imm_next = imm_reg;
    for (int c = 0; c < NCH; c++)
    begin
      src_next[c] = src_reg[c];
      fh_next[c] = fh_reg[c];
      fl_next[c] = fl_reg[c];
      lh_next[c] = lh_reg[c];
      ll_next[c] = ll_reg[c];
      pend_next[c] = pend_reg[c];
      act_next[c] = act_reg[c];
      if (field_start && pendf_reg[c])
      begin
        act_next[c] = pend_reg[c];
        pendf_next[c] = 1'b0;
      end
      if (wr && blk == 4'(c))
      begin
        case (rg)
          `OSR_CH_STATUS:
          begin
            blank_next[c] = pwdata[`OSR_ST_BLANK];
            imm_next[c] = pwdata[`OSR_ST_IMM];
          end
          `OSR_CH_SRC:
          begin
            src_next[c] = pwdata[7:0];
            pend_next[c].src = pwdata[7:0];
          end
          `OSR_CH_FIRST_H: fh_next[c] = pwdata[0];
          `OSR_CH_FIRST_L:
          begin
            fl_next[c] = pwdata[7:0];
            pend_next[c].first = {fh_reg[c], pwdata[7:0]};
          end
          `OSR_CH_LAST_H: lh_next[c] = pwdata[0];
          `OSR_CH_LAST_L:
          begin
            ll_next[c] = pwdata[7:0];
            pend_next[c].last = {lh_reg[c], pwdata[7:0]};
          end
          default: pend_next[c] = pend_reg[c];
        endcase
        if (rg == `OSR_CH_SRC || rg == `OSR_CH_FIRST_L ||
            rg == `OSR_CH_LAST_L)
        begin
          if (imm_reg[c])
          begin
            act_next[c] = pend_next[c];
            pendf_next[c] = 1'b0;
          end
          else
            pendf_next[c] = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // multichannel registers and multi-write engine
  function automatic logic [3:0] osr_lowest(input logic [7:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
      if (m[i])
        r = {1'b1, 3'(i)};
    return r;
  endfunction : osr_lowest

  logic mem_req_reg, mem_req_next;
  osr_memwr_s memwr_reg, memwr_next;
  logic [7:0] trig_left;
  logic [3:0] low;

  always_comb
  begin
    pix_next = pix_reg;
    col_next = col_reg;
    row_next = row_reg;
    trig_next = trig_reg;
    col_step_next = col_step_reg;
    row_step_next = row_step_reg;
    mw_next = mw_reg;
    // multichannel writes are refused while the engine runs
    if (wr && blk == `OSR_BLK_MULTI && mw_reg == OSR_MW_IDLE)
      case (rg)
        `OSR_MC_PIX_H: pix_next[15:8] = pwdata[7:0];
        `OSR_MC_PIX_L: pix_next[7:0] = pwdata[7:0];
        `OSR_MC_COL: col_next = pwdata[7:0];
        `OSR_MC_ROW_H: row_next[8] = pwdata[0];
        `OSR_MC_ROW_L: row_next[7:0] = pwdata[7:0];
        `OSR_MC_TRIG: trig_next = pwdata[7:0];
        `OSR_MC_CTRL:
        begin
          col_step_next = pwdata[`OSR_CTL_COL];
          row_step_next = pwdata[`OSR_CTL_ROW];
        end
        default: pix_next = pix_reg;
      endcase
    trig_left = trig_reg;
    case (mw_reg)
      OSR_MW_IDLE:
        if (trig_reg != 8'h00)
          mw_next = OSR_MW_REQ;
      OSR_MW_REQ:
        if (mem_req_reg && mem_wr_ack)
        begin
          trig_left[memwr_reg.chan] = 1'b0;
          trig_next = trig_left;
          if (trig_left == 8'h00)
            mw_next = OSR_MW_STEP;
        end
      OSR_MW_STEP:
      begin
        if (col_step_reg && col_reg < `OSR_COL_MAX)
          col_next = 8'(col_reg + 8'h01);
        if (row_step_reg && row_reg < `OSR_ROW_MAX)
          row_next = 9'(row_reg + 9'h001);
        mw_next = OSR_MW_IDLE;
      end
      default: mw_next = OSR_MW_IDLE;
    endcase
    low = osr_lowest(trig_next);
    mem_req_next = (mw_next == OSR_MW_REQ) && low[3];
    memwr_next.chan = low[2:0];
    memwr_next.col = col_reg;
    memwr_next.row = row_reg;
    memwr_next.data = pix_reg;
  end

  // ==========================================================
  // sync loss detection
  logic [7:0] sync_meta_reg, sync_s_reg, sync_d_reg;
  logic [9:0] cnt_reg [NCH];
  logic [9:0] cnt_next [NCH];
  logic [7:0] sync_edge;

  assign sync_edge = sync_s_reg & ~sync_d_reg;
  always_comb
  begin
    lost_next = lost_reg;
    for (int c = 0; c < NCH; c++)
    begin
      cnt_next[c] = cnt_reg[c];
      if (sync_edge[c])
      begin
        cnt_next[c] = 10'h000;
        lost_next[c] = 1'b0;
      end
      else if (cnt_reg[c] == LINE_CYC)
        lost_next[c] = 1'b1;
      else
        cnt_next[c] = 10'(cnt_reg[c] + 10'h001);
    end
  end

  // ==========================================================
  // overlay key and fetch source
  logic [7:0] key_n_reg, key_n_next;
  logic fv_reg, fv_next;
  logic [2:0] fch_reg, fch_next;
  logic [7:0] par_mask;
  logic [3:0] fsrc;
  osr_share_s fact;

  always_comb
  begin
    key_n_next = ~(gfx_on & ~blank_reg);
    fact = act_reg[fetch_chan];
    par_mask = fetch_chan[0] ? 8'hAA : 8'h55;
    fsrc = osr_lowest(fact.src & par_mask);
    fv_next = fetch_req;
    fch_next = fetch_chan;
    if (fetch_req && fsrc[3] && fetch_line >= fact.first &&
        fetch_line <= fact.last)
      fch_next = fsrc[2:0];
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pendf_reg <= `OSR_RST_BYTE;
      blank_reg <= `OSR_RST_BYTE;
      imm_reg <= `OSR_RST_BYTE;
      lost_reg <= `OSR_RST_BYTE;
      pix_reg <= 16'h0000;
      col_reg <= `OSR_RST_BYTE;
      row_reg <= 9'h000;
      trig_reg <= `OSR_RST_BYTE;
      col_step_reg <= 1'b0;
      row_step_reg <= 1'b0;
      mw_reg <= OSR_MW_IDLE;
      mem_req_reg <= 1'b0;
      memwr_reg <= '0;
      sync_meta_reg <= 8'h00;
      sync_s_reg <= 8'h00;
      sync_d_reg <= 8'h00;
      key_n_reg <= 8'hFF;
      fv_reg <= 1'b0;
      fch_reg <= 3'h0;
      for (int c = 0; c < NCH; c++)
      begin
        src_reg[c] <= `OSR_RST_BYTE;
        fh_reg[c] <= 1'b0;
        fl_reg[c] <= `OSR_RST_BYTE;
        lh_reg[c] <= 1'b0;
        ll_reg[c] <= `OSR_RST_BYTE;
        pend_reg[c] <= '0;
        act_reg[c] <= '0;
        cnt_reg[c] <= 10'h000;
      end
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      pendf_reg <= pendf_next;
      blank_reg <= blank_next;
      imm_reg <= imm_next;
      lost_reg <= lost_next;
      pix_reg <= pix_next;
      col_reg <= col_next;
      row_reg <= row_next;
      trig_reg <= trig_next;
      col_step_reg <= col_step_next;
      row_step_reg <= row_step_next;
      mw_reg <= mw_next;
      mem_req_reg <= mem_req_next;
      memwr_reg <= memwr_next;
      sync_meta_reg <= sync_in;
      sync_s_reg <= sync_meta_reg;
      sync_d_reg <= sync_s_reg;
      key_n_reg <= key_n_next;
      fv_reg <= fv_next;
      fch_reg <= fch_next;
      for (int c = 0; c < NCH; c++)
      begin
        src_reg[c] <= src_next[c];
        fh_reg[c] <= fh_next[c];
        fl_reg[c] <= fl_next[c];
        lh_reg[c] <= lh_next[c];
        ll_reg[c] <= ll_next[c];
        pend_reg[c] <= pend_next[c];
        act_reg[c] <= act_next[c];
        cnt_reg[c] <= cnt_next[c];
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign overlay_key_n = key_n_reg;
  assign fetch_valid = fv_reg;
  assign fetch_mem_chan = fch_reg;
  assign mem_wr_req = mem_req_reg;
  assign mem_wr = memwr_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_ch(logic [3:0] b, logic [3:0] r);
    wr && blk == b && rg == r;
  endsequence
  sequence s_trig_wr;
    wr && blk == `OSR_BLK_MULTI && rg == `OSR_MC_TRIG &&
      mw_reg == OSR_MW_IDLE && pwdata[7:0] != 8'h00;
  endsequence

  a_high_no_commit: assert property (
    s_wr_ch(4'h2, `OSR_CH_FIRST_H) ##0 !field_start |=>
      $stable(act_reg[2]))
    else $error("high write changed committed first line");
  a_imm_commit: assert property (
    s_wr_ch(4'h2, `OSR_CH_LAST_L) ##0 imm_reg[2] |=>
      act_reg[2].last == {$past(lh_reg[2]), $past(pwdata[7:0])})
    else $error("immediate last line commit wrong");
  a_defer_commit: assert property (
    s_wr_ch(4'h5, `OSR_CH_LAST_L) ##0 (!imm_reg[5] && !field_start) |=>
      $stable(act_reg[5]) && pendf_reg[5])
    else $error("deferred commit applied early");
  a_col_range: assert property (mw_reg == OSR_MW_STEP &&
    $past(col_reg) == `OSR_COL_MAX |=> col_reg == `OSR_COL_MAX)
    else $error("column stepped past limit");
  a_trig_clear: assert property (
    mw_reg == OSR_MW_STEP |-> trig_reg == 8'h00)
    else $error("trigger not clear at completion");
  a_mw_start: assert property (
    s_trig_wr |-> ##[1:2] mem_wr_req)
    else $error("multi-write did not start");
  a_sync_set: assert property (
    cnt_reg[0] == LINE_CYC && !sync_edge[0] |=> lost_reg[0])
    else $error("sync loss flag not set");
  a_sync_clear: assert property (
    sync_edge[0] |=> !lost_reg[0] && cnt_reg[0] == 10'h000)
    else $error("sync loss flag not cleared");
  a_blank_key: assert property (
    blank_reg[1] |=> overlay_key_n[1])
    else $error("overlay key active while suppressed");
  a_step_once: assert property (
    mw_reg == OSR_MW_STEP |=> mw_reg == OSR_MW_IDLE && !mem_wr_req)
    else $error("step not single");
endmodule : osr_regs
`default_nettype wire

// >>> logic/osr_map.svh
`ifndef OSR_MAP_SVH
`define OSR_MAP_SVH
// ==========================================================
// register indices (byte address = index * 4)
`define OSR_BLK_MULTI 4'h8
`define OSR_CH_STATUS 4'h5
`define OSR_CH_SRC 4'h9
`define OSR_CH_FIRST_H 4'hA
`define OSR_CH_FIRST_L 4'hB
`define OSR_CH_LAST_H 4'hC
`define OSR_CH_LAST_L 4'hD
`define OSR_MC_PIX_H 4'h0
`define OSR_MC_PIX_L 4'h1
`define OSR_MC_COL 4'h2
`define OSR_MC_ROW_H 4'h3
`define OSR_MC_ROW_L 4'h4
`define OSR_MC_LOSS 4'h5
`define OSR_MC_TRIG 4'h6
`define OSR_MC_CTRL 4'h7
// ==========================================================
// field positions
`define OSR_ST_LOST 0
`define OSR_ST_BLANK 1
`define OSR_ST_IMM 2
`define OSR_CTL_COL 3
`define OSR_CTL_ROW 4
// ==========================================================
// limits, reset values, timing
`define OSR_COL_MAX 8'hB1
`define OSR_ROW_MAX 9'h1FF
`define OSR_RST_BYTE 8'h00
`define OSR_LINE_NS 63556
`define OSR_CLK_NS 100
`define OSR_LINE_CYC ((`OSR_LINE_NS) / (`OSR_CLK_NS))
`endif

// >>> logic/osr_pkg.sv
`default_nettype none
package osr_pkg;
  typedef enum logic [1:0] {
    OSR_MW_IDLE = 2'b00,
    OSR_MW_REQ = 2'b01,
    OSR_MW_STEP = 2'b10
  } osr_mw_e;
  typedef struct packed {
    logic [2:0] chan;
    logic [7:0] col;
    logic [8:0] row;
    logic [15:0] data;
  } osr_memwr_s;
  typedef struct packed {
    logic [7:0] src;
    logic [8:0] first;
    logic [8:0] last;
  } osr_share_s;
endpackage : osr_pkg
`default_nettype wire

// >>> logic/osr_regs_unused_note.sv
`default_nettype none
`default_nettype wire

// >>> test/osr_mem_model.sv
`default_nettype none
module osr_mem_model
  import osr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frame memory write port
  input wire logic mem_wr_req,
  input wire osr_memwr_s mem_wr,
  output logic mem_wr_ack,
  // latency control and write log
  input wire logic [3:0] lat,
  output logic [3:0] wr_cnt,
  output osr_memwr_s wr_log [8]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // one-cycle ack after lat idle cycles; ack never stands without a request
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_wr_ack <= 1'b0;
      wait_cnt <= 4'h0;
      wr_cnt <= 4'h0;
    end
    else if (mem_wr_ack)
    begin
      mem_wr_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (mem_wr_req)
    begin
      if (wait_cnt >= lat)
      begin
        mem_wr_ack <= 1'b1;
        wr_log[wr_cnt[2:0]] <= mem_wr;
        wr_cnt <= wr_cnt + 4'h1;
      end
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : osr_mem_model
`default_nettype wire

// >>> test/tb_osr_regs.sv
`include "osr_map.svh"
`default_nettype none
module tb_osr_regs
  import osr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] sync_in, gfx_on, key_n, sync_mask, scnt;
  logic field_start, fetch_req, fetch_valid, mem_wr_req, mem_wr_ack;
  logic [2:0] fetch_chan, fetch_mem_chan;
  logic [8:0] fetch_line;
  logic [3:0] lat, wr_cnt;
  osr_memwr_s mem_wr;
  osr_memwr_s wr_log [8];
  int errors, comparisons;

  osr_regs #(.LINE_CYC(10'h014)) i_osr_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .field_start(field_start), .gfx_on(gfx_on),
    .overlay_key_n(key_n), .fetch_req(fetch_req), .fetch_chan(fetch_chan),
    .fetch_line(fetch_line), .fetch_valid(fetch_valid),
    .fetch_mem_chan(fetch_mem_chan), .mem_wr_req(mem_wr_req),
    .mem_wr(mem_wr), .mem_wr_ack(mem_wr_ack));
  osr_mem_model i_osr_mem_model (.pclk(pclk), .presetn(presetn),
    .mem_wr_req(mem_wr_req), .mem_wr(mem_wr), .mem_wr_ack(mem_wr_ack),
    .lat(lat), .wr_cnt(wr_cnt), .wr_log(wr_log));

  // ==========================================================
  // clock, sync pulses, watchdog
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    if (!presetn)
      scnt <= 8'h00;
    else
      scnt <= scnt + 8'h01;
    sync_in <= (scnt[2:0] == 3'h0) ? sync_mask : 8'h00;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [11:0] ad(input logic [3:0] b, input logic [3:0] r);
    return {2'b00, b, r, 2'b00};
  endfunction : ad
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken at the rising edge that sees pready high
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    chk(prdata[31:8], 24'h000000);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r, x);
  endtask : rd
  task automatic fq(input logic [2:0] c, input logic [8:0] l,
    input logic [2:0] x);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fetch_chan <= c;
    fetch_line <= l;
    @(posedge pclk);
    fetch_req <= 1'b0;
    @(negedge pclk);
    chk({fetch_valid, fetch_mem_chan}, {1'b1, x});
  endtask : fq
  task automatic wait_idle();
    logic [7:0] r;
    logic e;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, ad(4'h8, 4'h6), 8'h00, r, e);
      n++;
    end
    while (r !== 8'h00 && n < 30);
    chk(r, 8'h00);
  endtask : wait_idle

  // ==========================================================
  // scenarios
  task automatic t_basic();
    logic [7:0] r;
    logic e;
    rd(ad(4'h8, 4'h7), 8'h00);
    rd(ad(4'h8, 4'h6), 8'h00);
    rd(ad(4'h0, 4'h9), 8'h00);
    @(negedge pclk);
    chk(key_n, 8'hFF);
    wr(ad(4'h8, 4'h7), 8'hFF);
    rd(ad(4'h8, 4'h7), 8'h18);
    wr(ad(4'h8, 4'h0), 8'hAB);
    rd(ad(4'h8, 4'h0), 8'hAB);
    apb(1'b0, ad(4'h8, 4'hF), 8'h00, r, e);
    chk(e, 1'b1);
    $display("test basic done");
  endtask : t_basic
  task automatic t_share();
    wr(ad(4'h2, 4'h5), 8'h04);
    wr(ad(4'h2, 4'h9), 8'h15);
    wr(ad(4'h2, 4'hA), 8'h01);
    wr(ad(4'h2, 4'hB), 8'h05);
    wr(ad(4'h2, 4'hC), 8'h01);
    wr(ad(4'h2, 4'hD), 8'h0A);
    fq(3'd2, 9'h106, 3'd0);
    fq(3'd2, 9'h104, 3'd2);
    fq(3'd2, 9'h10B, 3'd2);
    fq(3'd2, 9'h10A, 3'd0);
    wr(ad(4'h2, 4'hA), 8'h00);
    fq(3'd2, 9'h010, 3'd2);
    wr(ad(4'h2, 4'hC), 8'h00);
    fq(3'd2, 9'h109, 3'd0);
    wr(ad(4'h5, 4'hA), 8'h00);
    wr(ad(4'h5, 4'hB), 8'h00);
    wr(ad(4'h5, 4'hC), 8'h00);
    wr(ad(4'h5, 4'hD), 8'h05);
    wr(ad(4'h5, 4'h9), 8'h0A);
    fq(3'd5, 9'h003, 3'd5);
    @(posedge pclk);
    field_start <= 1'b1;
    @(posedge pclk);
    field_start <= 1'b0;
    fq(3'd5, 9'h003, 3'd1);
    fq(3'd5, 9'h006, 3'd5);
    $display("test share done");
  endtask : t_share
  task automatic t_multi();
    wr(ad(4'h8, 4'h1), 8'hCD);
    wr(ad(4'h8, 4'h2), 8'hB0);
    wr(ad(4'h8, 4'h3), 8'h01);
    wr(ad(4'h8, 4'h4), 8'hFE);
    wr(ad(4'h8, 4'h6), 8'h05);
    wait_idle();
    chk(wr_cnt, 4'h2);
    chk(wr_log[0], {3'd0, 8'hB0, 9'h1FE, 16'hABCD});
    chk(wr_log[1], {3'd2, 8'hB0, 9'h1FE, 16'hABCD});
    rd(ad(4'h8, 4'h2), 8'hB1);
    rd(ad(4'h8, 4'h4), 8'hFF);
    rd(ad(4'h8, 4'h3), 8'h01);
    lat <= 4'h6;
    wr(ad(4'h8, 4'h6), 8'h80);
    wr(ad(4'h8, 4'h2), 8'h00);
    wait_idle();
    chk(wr_cnt, 4'h3);
    chk(wr_log[2], {3'd7, 8'hB1, 9'h1FF, 16'hABCD});
    rd(ad(4'h8, 4'h2), 8'hB1);
    rd(ad(4'h8, 4'h4), 8'hFF);
    $display("test multi done");
  endtask : t_multi
  task automatic t_sync();
    repeat (40) @(posedge pclk);
    rd(ad(4'h8, 4'h5), 8'hFF);
    rd(ad(4'h5, 4'h5), 8'h01);
    sync_mask <= 8'hDF;
    repeat (40) @(posedge pclk);
    rd(ad(4'h8, 4'h5), 8'h20);
    wr(ad(4'h5, 4'h5), 8'h02);
    sync_mask <= 8'hFF;
    repeat (40) @(posedge pclk);
    rd(ad(4'h8, 4'h5), 8'h00);
    rd(ad(4'h5, 4'h5), 8'h02);
    wr(ad(4'h5, 4'h5), 8'h00);
    $display("test sync done");
  endtask : t_sync
  task automatic t_key();
    gfx_on <= 8'hFF;
    wr(ad(4'h1, 4'h5), 8'h02);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(key_n, 8'h02);
    wr(ad(4'h1, 4'h5), 8'h00);
    gfx_on <= 8'hF0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(key_n, 8'h0F);
    $display("test key done");
  endtask : t_key
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, field_start, fetch_req} = 6'h00;
    {paddr, pwdata} = 64'h0;
    {gfx_on, sync_mask} = 16'h0000;
    fetch_chan = 3'd0;
    fetch_line = 9'h000;
    lat = 4'h1;
    errors = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_basic();
    t_share();
    t_multi();
    t_sync();
    t_key();
    give_verdict();
  end
endmodule : tb_osr_regs
`default_nettype wire
